// ===== rtl/msc_pkg.sv
// Shared constants for the measurement mode and command control pair.
// Assumes a single 25 MHz clock shared by both ends.
package msc_pkg;
    localparam int CLK_HZ         = 25_000_000;
    localparam int SAMPLE_TIME_US = 250;
    localparam int SAMPLE_CYC     = SAMPLE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int RATE_SCALE     = 1000;

    // Device register offsets.
    localparam logic [7:0] REG_OSR     = 8'h36;
    localparam logic [7:0] REG_RATE    = 8'h37;
    localparam logic [7:0] REG_EFF_OSR = 8'h38;
    localparam logic [7:0] REG_CMD     = 8'h7E;
    localparam logic [7:0] REG_PAGE    = 8'h7F;

    // Field positions and reset values.
    localparam int MODE_LSB     = 0;
    localparam int RATE_LSB     = 2;
    localparam int DEEP_DIS_BIT = 7;
    localparam int OSR_T_LSB    = 0;
    localparam int OSR_P_LSB    = 3;
    localparam int PRESS_EN_BIT = 6;
    localparam int VALID_BIT    = 7;
    localparam int PAGE_EN_BIT  = 0;
    localparam logic [7:0] RATE_RST    = 8'h70;
    localparam logic [7:0] OSR_RST     = 8'h00;
    localparam logic [2:0] OSR_DEFAULT = 3'h0;

    // Command codes.
    localparam logic [7:0] CMD_NONE     = 8'h00;
    localparam logic [7:0] CMD_NVM_1ST  = 8'h5D;
    localparam logic [7:0] CMD_NVM_WR   = 8'hA0;
    localparam logic [7:0] CMD_NVM_RD   = 8'hA5;
    localparam logic [7:0] CMD_EXT_1    = 8'h73;
    localparam logic [7:0] CMD_EXT_2    = 8'hB4;
    localparam logic [7:0] CMD_EXT_3    = 8'h69;
    localparam logic [7:0] CMD_SOFT_RST = 8'hB6;

    typedef enum logic [1:0] {
        MSC_STANDBY = 2'b00,
        MSC_NORMAL  = 2'b01,
        MSC_FORCED  = 2'b10,
        MSC_NONSTOP = 2'b11
    } msc_mode_t;

    // Normal-mode rates in millihertz, code 0 first.
    localparam int RATE_MHZ [32] = '{
        240000, 218537, 199111, 179200, 160000, 149333, 140000, 129855,
        120000, 110164, 100299, 89600, 80000, 70000, 60000, 50056,
        45025, 40000, 35000, 30000, 25005, 20000, 15000, 10000,
        5000, 4000, 3000, 2000, 1000, 500, 250, 125};

    // Host controller APB map and fields.
    localparam logic [7:0] HOST_CMD    = 8'h00;
    localparam logic [7:0] HOST_STAT   = 8'h04;
    localparam logic [7:0] HOST_INT_ST = 8'h08;
    localparam logic [7:0] HOST_INT_MK = 8'h0C;
    localparam int H_WDATA_LSB = 8;
    localparam int H_WRITE_BIT = 16;
    localparam int H_BUSY_BIT  = 8;
    localparam int H_ERR_BIT   = 9;
    localparam int INT_DONE    = 0;
    localparam int INT_ERR     = 1;
endpackage : msc_pkg

// ===== rtl/msc_link_if.sv
// Register link between the host controller and the sensor control logic.
// Both ends run on the same clock; req is held until ack or nack.
`timescale 1ns/1ps
`default_nettype none
interface msc_link_if;
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    logic       nack;

    modport dev  (input req, we, addr, wdata, output rdata, ack, nack);
    modport host (output req, we, addr, wdata, input rdata, ack, nack);
endinterface : msc_link_if
`default_nettype wire

// ===== rtl/msc_rate_timer.sv
// Normal-mode timebase and rate/oversampling compatibility check.
// Assumes the rate and oversampling inputs come from registers.
`timescale 1ns/1ps
`default_nettype none
module msc_rate_timer import msc_pkg::*; #(
    parameter int CLK_HZ_P  = CLK_HZ,
    parameter int SAMPLE_P  = SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    // Configuration
    input  wire logic       run_in,
    input  wire logic [4:0] odr_in,
    input  wire logic [2:0] osr_t_in,
    input  wire logic [2:0] osr_p_in,
    input  wire logic       press_en_in,
    // Results
    output logic            tick_out,
    output logic            valid_out
);
    logic [31:0] period_tab [32];
    logic [31:0] cnt_q;
    logic [31:0] period;
    logic [63:0] cost;

    for (genvar g = 0; g < 32; g++) begin : g_tab
        assign period_tab[g] = 32'(64'(CLK_HZ_P) * RATE_SCALE / RATE_MHZ[g]);
    end

    assign period = period_tab[odr_in];
    // Each sample costs a fixed conversion time; OSR codes double it.
    assign cost = 64'((32'h1 << osr_t_in) + (press_en_in ? (32'h1 << osr_p_in) : 32'h0))
                  * 64'(SAMPLE_P);
    assign valid_out = (cost <= 64'(period));

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !run_in) begin
            cnt_q    <= 32'h0;
            tick_out <= 1'b0;
        end else if (cnt_q >= period - 32'h1) begin
            cnt_q    <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule : msc_rate_timer
`default_nettype wire

// ===== rtl/msc_dev_end.sv
// Sensor side: mode control, rate check and command decoder.
// Assumes the host holds req until it sees ack or nack; the measurement
// engine pulses meas_done_in once per started measurement.
//
// Local design decision: the register link port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - mode write requests, read returns actual mode
// - modes standby, normal, forced, non-stop
// - forced completion returns mode to standby
// - five-bit rate code selects 32 rates
// - invalid combination falls back to default oversampling
// - validity flag recomputed on every change
// - effective oversampling reported in status register
// - oversampling codes are powers of two
// - deep standby off while bit set
// - command register reads zero
// - 5D then A0 enables memory programming
// - 5D then A5 enables memory read
// - wrong code abandons partial sequence
// - 73, B4, 69 enters extended mode
// - B6 soft reset restores defaults
// - soft reset write is not acknowledged
module msc_dev_end import msc_pkg::*; #(
    parameter int CLK_HZ_P = CLK_HZ,
    parameter int SAMPLE_P = SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic   clock_in,
    input  wire logic   sys_rst_in,
    // Register link
    msc_link_if.dev     link,
    // Measurement engine
    input  wire logic   meas_done_in,
    output logic        meas_start_out,
    output logic        conv_busy_out,
    // Device state
    output logic        deep_stby_en_out,
    output logic        nvm_prog_en_out,
    output logic        nvm_read_en_out,
    output logic        extended_page_select_out,
    output logic        soft_reset_out
);
    msc_mode_t   mode_q, mode_d;
    logic [4:0]  odr_q;
    logic        deep_dis_q;
    logic [7:0]  osr_q;
    logic [7:0]  eff_osr_q;
    logic        busy_q;
    logic        start_d;
    logic        nvm_step_q;
    logic [1:0]  ext_step_q;
    logic        ack_q, nack_q;
    logic [7:0]  rdata_q;
    logic        tick, valid;

    // Decode.
    wire       take     = link.req & ~ack_q & ~nack_q;
    wire       wr       = take & link.we;
    wire [7:0] code     = link.wdata;
    wire       wr_rate  = wr & (link.addr == REG_RATE);
    wire       wr_osr   = wr & (link.addr == REG_OSR);
    wire       wr_cmd   = wr & (link.addr == REG_CMD);
    wire       wr_page  = wr & (link.addr == REG_PAGE);
    wire       srst     = wr_cmd & (code == CMD_SOFT_RST);
    wire       cfg_rst  = sys_rst_in | srst;
    wire [2:0] osr_t    = osr_q[OSR_T_LSB +: 3];
    wire [2:0] osr_p    = osr_q[OSR_P_LSB +: 3];
    wire       press_en = osr_q[PRESS_EN_BIT];
    wire [1:0] mode_req = code[MODE_LSB +: 2];
    wire [7:0] rate_rd  = {deep_dis_q, odr_q, mode_q};
    wire [7:0] page_rd  = {7'h0, extended_page_select_out};
    wire [7:0] rd_mux   = (link.addr == REG_RATE)    ? rate_rd   :
                          (link.addr == REG_OSR)     ? osr_q     :
                          (link.addr == REG_EFF_OSR) ? eff_osr_q :
                          (link.addr == REG_PAGE)    ? page_rd   :
                          8'h00;
    // Fallback keeps measurements going at the chosen rate.
    wire [7:0] eff_d    = valid ? {valid, 1'b0, osr_p, osr_t}
                                : {1'b0, 1'b0, OSR_DEFAULT, OSR_DEFAULT};

    msc_rate_timer #(
        .CLK_HZ_P (CLK_HZ_P),
        .SAMPLE_P (SAMPLE_P)
    ) u_timer (
        .clock_in    (clock_in),
        .sys_rst_in  (cfg_rst),
        .run_in      (mode_q == MSC_NORMAL),
        .odr_in      (odr_q),
        .osr_t_in    (osr_t),
        .osr_p_in    (osr_p),
        .press_en_in (press_en),
        .tick_out    (tick),
        .valid_out   (valid)
    );

    // Mode sequencing; a host mode write overrides the hardware step.
    always_comb begin
        mode_d  = mode_q;
        start_d = 1'b0;
        case (mode_q)
            MSC_STANDBY: begin
                mode_d = MSC_STANDBY;
            end
            MSC_NORMAL: begin
                start_d = tick & ~busy_q;
            end
            MSC_FORCED: begin
                if (busy_q && meas_done_in) begin
                    mode_d = MSC_STANDBY;
                end else if (!busy_q && !meas_start_out) begin
                    start_d = 1'b1;
                end
            end
            MSC_NONSTOP: begin
                start_d = ~busy_q;
            end
            default: begin
                mode_d = MSC_STANDBY;
            end
        endcase
        if (wr_rate) begin
            mode_d = msc_mode_t'(mode_req);
        end
    end

    always_ff @(posedge clock_in) begin
        if (cfg_rst) begin
            mode_q     <= msc_mode_t'(RATE_RST[MODE_LSB +: 2]);
            odr_q      <= RATE_RST[RATE_LSB +: 5];
            deep_dis_q <= RATE_RST[DEEP_DIS_BIT];
            osr_q      <= OSR_RST;
        end else begin
            mode_q <= mode_d;
            if (wr_rate) begin
                odr_q <= code[RATE_LSB +: 5];
            end
            // A conversion in flight keeps its deep standby setting.
            if (wr_rate && !busy_q) begin
                deep_dis_q <= code[DEEP_DIS_BIT];
            end
            if (wr_osr) begin
                osr_q <= {1'b0, code[6:0]};
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (cfg_rst) begin
            busy_q           <= 1'b0;
            meas_start_out   <= 1'b0;
            eff_osr_q        <= 8'h00;
            deep_stby_en_out <= 1'b0;
        end else begin
            busy_q           <= start_d | (busy_q & ~meas_done_in);
            meas_start_out   <= start_d;
            eff_osr_q        <= eff_d;
            deep_stby_en_out <= (mode_q == MSC_STANDBY) & ~deep_dis_q & ~busy_q;
        end
    end

    // Unlock sequences; any other code restarts them from the first step.
    always_ff @(posedge clock_in) begin
        if (cfg_rst) begin
            nvm_step_q      <= 1'b0;
            ext_step_q      <= 2'h0;
            nvm_prog_en_out <= 1'b0;
            nvm_read_en_out <= 1'b0;
            extended_page_select_out <= 1'b0;
        end else begin
            if (wr_cmd) begin
                nvm_step_q <= (code == CMD_NVM_1ST);
                if (nvm_step_q && code == CMD_NVM_WR) begin
                    nvm_prog_en_out <= 1'b1;
                end
                if (nvm_step_q && code == CMD_NVM_RD) begin
                    nvm_read_en_out <= 1'b1;
                end
                if (code == CMD_EXT_1) begin
                    ext_step_q <= 2'h1;
                end else if (ext_step_q == 2'h1 && code == CMD_EXT_2) begin
                    ext_step_q <= 2'h2;
                end else begin
                    ext_step_q <= 2'h0;
                end
                if (ext_step_q == 2'h2 && code == CMD_EXT_3) begin
                    extended_page_select_out <= 1'b1;
                end
            end
            if (wr_page && !code[PAGE_EN_BIT]) begin
                extended_page_select_out <= 1'b0;
            end
        end
    end

    // Link answers one cycle after the request is taken.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ack_q          <= 1'b0;
            nack_q         <= 1'b0;
            rdata_q        <= 8'h00;
            soft_reset_out <= 1'b0;
            conv_busy_out  <= 1'b0;
        end else begin
            ack_q          <= take & ~srst;
            nack_q         <= srst;
            rdata_q        <= (take && !link.we) ? rd_mux : 8'h00;
            soft_reset_out <= srst;
            conv_busy_out  <= busy_q & ~srst;
        end
    end

    assign link.ack   = ack_q;
    assign link.nack  = nack_q;
    assign link.rdata = rdata_q;
endmodule : msc_dev_end
`default_nettype wire

// ===== rtl/msc_host_end.sv
// Host controller: APB registers turn into single link transfers.
// Assumes software writes one order at a time and polls or waits for irq.
`timescale 1ns/1ps
`default_nettype none
module msc_host_end import msc_pkg::*; (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    // Register link
    msc_link_if.host         link
);
    logic       req_q, we_q;
    logic [7:0] addr_q, wdata_q, rdata_q;
    logic       err_q;
    logic [1:0] int_st_q, int_mk_q;

    wire       acc    = psel_in & penable_in & ~pready_out;
    wire       done   = psel_in & penable_in & pready_out & pwrite_in;
    wire       answer = req_q & (link.ack | link.nack);
    wire [7:0] ord_a  = pwdata_in[7:0];
    wire [7:0] ord_d  = pwdata_in[H_WDATA_LSB +: 8];
    wire       ord_w  = pwdata_in[H_WRITE_BIT];
    wire       is_cmd = ord_w & (ord_a == REG_CMD);
    wire       legal  = (ord_d == CMD_NVM_1ST) | (ord_d == CMD_NVM_WR) |
                        (ord_d == CMD_NVM_RD) | (ord_d == CMD_EXT_1) |
                        (ord_d == CMD_EXT_2) | (ord_d == CMD_EXT_3) |
                        (ord_d == CMD_SOFT_RST) | (ord_d == CMD_NONE);
    wire       go     = done & (paddr_in == HOST_CMD) & ~req_q;
    wire       refuse = go & is_cmd & ~legal;
    // A missing acknowledge on soft reset means the write landed.
    wire       srst_w = we_q & (addr_q == REG_CMD) & (wdata_q == CMD_SOFT_RST);
    wire       bad    = answer & link.nack & ~srst_w;
    wire [1:0] ev     = {bad | refuse, answer};
    wire [1:0] clr    = (done && paddr_in == HOST_INT_ST) ? pwdata_in[1:0] : 2'h0;
    wire [1:0] ist_d  = (int_st_q & ~clr) | ev;
    wire [31:0] rd_mux =
        (paddr_in == HOST_CMD)    ? {15'h0, we_q, wdata_q, addr_q} :
        (paddr_in == HOST_STAT)   ? {22'h0, err_q, req_q, rdata_q} :
        (paddr_in == HOST_INT_ST) ? {30'h0, int_st_q} :
        (paddr_in == HOST_INT_MK) ? {30'h0, int_mk_q} : 32'h0;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0;
            pslverr_out <= 1'b0;
            int_st_q    <= 2'h0;
            int_mk_q    <= 2'h0;
            irq_out     <= 1'b0;
        end else begin
            pready_out  <= acc;
            prdata_out  <= (acc && !pwrite_in) ? rd_mux : 32'h0;
            pslverr_out <= 1'b0;
            int_st_q    <= ist_d;
            if (done && paddr_in == HOST_INT_MK) begin
                int_mk_q <= pwdata_in[1:0];
            end
            irq_out     <= |(ist_d & int_mk_q);
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            req_q   <= 1'b0;
            we_q    <= 1'b0;
            addr_q  <= 8'h00;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            err_q   <= 1'b0;
        end else if (go && !refuse) begin
            req_q   <= 1'b1;
            we_q    <= ord_w;
            addr_q  <= ord_a;
            wdata_q <= ord_d;
            err_q   <= 1'b0;
        end else if (refuse) begin
            err_q   <= 1'b1;
        end else if (answer) begin
            req_q   <= 1'b0;
            rdata_q <= link.ack ? link.rdata : 8'h00;
            err_q   <= bad;
        end
    end

    assign link.req   = req_q;
    assign link.we    = we_q;
    assign link.addr  = addr_q;
    assign link.wdata = wdata_q;
endmodule : msc_host_end
`default_nettype wire

// ===== sim/msc_checker.sv
// Checker for the register link that joins the host end to the device end.
// Assumes one shared clock and the synchronous active-high reset of both ends.
`timescale 1ns/1ps
`default_nettype none
module msc_checker import msc_pkg::*; (
    // Clock and reset
    input wire logic       clock_in,
    input wire logic       sys_rst_in,
    // Link signals
    input wire logic       req,
    input wire logic       we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       nack
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_taken;
        req && !ack && !nack;
    endsequence
    sequence s_soft_wr;
        s_taken ##0 (we && addr == REG_CMD && wdata == CMD_SOFT_RST);
    endsequence
    sequence s_eff_rd;
        ack && !we && addr == REG_EFF_OSR;
    endsequence

    answer_next_a : assert property (s_taken |=> (ack ^ nack))
        else $error("link request not answered in one cycle");
    soft_nack_a : assert property (s_soft_wr |=> nack && !ack)
        else $error("soft reset write was acknowledged");
    nack_cause_a : assert property (nack |-> $past(we && addr == REG_CMD && wdata == CMD_SOFT_RST))
        else $error("refusal without a soft reset write");
    cmd_zero_a : assert property (ack && !we && addr == REG_CMD |-> rdata == 8'h00)
        else $error("command register read back nonzero");
    eff_reserved_a : assert property (s_eff_rd |-> !rdata[6])
        else $error("reserved status bit set");
    eff_fallback_a : assert property (s_eff_rd ##0 !rdata[VALID_BIT] |-> rdata[5:0] == 6'h00)
        else $error("invalid setting without default oversampling");
    req_hold_a : assert property (s_taken |=> req && $stable({we, addr, wdata}))
        else $error("request changed before its answer");
    answer_pulse_a : assert property ((ack || nack) |=> !(ack || nack) [*2])
        else $error("answer longer than one cycle");
    rdata_idle_a : assert property (!ack |-> rdata == 8'h00)
        else $error("read data outside the answer cycle");
endmodule : msc_checker
`default_nettype wire

// ===== sim/tb.sv
// Testbench: drives the host end over APB and checks both ends joined by the link.
// Assumes the shortened timebase set on the device end: period = CLK_P*1000/rate_mHz.
`timescale 1ns/1ps
`default_nettype none
module tb import msc_pkg::*;;
    localparam int CLK_P = 25_000;
    localparam int SMP_P = 4;
    logic        clock_in   = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        irq;
    logic        meas_done  = 1'b0;
    logic [2:0]  done_dly   = 3'h0;
    logic        meas_start;
    logic        deep_stby;
    logic        nvm_prog;
    logic        nvm_read;
    logic        extended_page_select;
    logic        conv_busy;
    logic        soft_rst;
    logic        pslverr;
    int          n_busy     = 0;
    int          n_srst     = 0;
    int          n_start    = 0;
    int          err_total  = 0;
    int          n_compared = 0;

    msc_link_if link ();
    msc_host_end u_msc_host_end (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
        .link(link));
    msc_dev_end #(.CLK_HZ_P(CLK_P), .SAMPLE_P(SMP_P)) u_msc_dev_end (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .link(link), .meas_done_in(meas_done),
        .meas_start_out(meas_start), .conv_busy_out(conv_busy), .deep_stby_en_out(deep_stby),
        .nvm_prog_en_out(nvm_prog), .nvm_read_en_out(nvm_read),
        .extended_page_select_out(extended_page_select), .soft_reset_out(soft_rst));
    msc_checker u_msc_checker (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .req(link.req),
        .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .ack(link.ack), .nack(link.nack));

    initial begin
        forever #20 clock_in = ~clock_in;
    end

    // The measurement engine answers each start four cycles later.
    always @(posedge clock_in) begin
        done_dly  <= {done_dly[1:0], meas_start};
        meas_done <= done_dly[2];
        if (meas_start === 1'b1) begin
            n_start <= n_start + 1;
        end
        if (conv_busy === 1'b1) begin
            n_busy <= n_busy + 1;
        end
        if (soft_rst === 1'b1) begin
            n_srst <= n_srst + 1;
        end
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock_in);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        // Pready and prdata are taken as they stand at the completing rising edge.
        do begin
            @(posedge clock_in);
            n++;
            if (n > 50) begin
                err_total++;
                give_verdict();
            end
        end while (pready !== 1'b1);
        r = prdata;
        chk(pslverr, 1'b0);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    // One device register transfer through the host: order, then poll until idle.
    task automatic lop(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        logic [31:0] s;
        int n;
        n = 0;
        apb(1'b1, HOST_CMD, {15'h0, w, d, a}, s);
        do begin
            apb(1'b0, HOST_STAT, 32'h0, s);
            n++;
            if (n > 20) begin
                err_total++;
                give_verdict();
            end
        end while (s[H_BUSY_BIT] !== 1'b0);
        r = s[7:0];
    endtask : lop

    task automatic dw(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        lop(1'b1, a, d, r);
    endtask : dw

    task automatic dchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        lop(1'b0, a, 8'h00, r);
        chk(r, exp);
    endtask : dchk

    initial begin
        logic [31:0] s;
        logic [7:0]  r;
        int          k;
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        dchk(REG_RATE, RATE_RST);
        dchk(REG_EFF_OSR, 8'h80);
        chk(deep_stby, 1'b1);
        dw(REG_RATE, 8'hF0);
        chk(deep_stby, 1'b0);
        dchk(REG_RATE, 8'hF0);
        apb(1'b0, 8'h10, 32'h0, s);
        chk(s, 32'h0);
        $display("test reset_and_standby done");
        k = n_start;
        r = 8'h00;
        dw(REG_RATE, 8'h72);
        for (int i = 0; i < 10 && r !== RATE_RST; i++) begin
            lop(1'b0, REG_RATE, 8'h00, r);
        end
        chk(r, RATE_RST);
        chk(n_start - k, 32'd1);
        k = n_start;
        dw(REG_RATE, 8'h73);
        repeat (100) @(posedge clock_in);
        dw(REG_RATE, 8'h70);
        chk(n_start - k > 10, 1'b1);
        chk(n_busy > 0, 1'b1);
        // Code 0 gives a period of 104 cycles with the shortened timebase.
        dw(REG_RATE, 8'h01);
        k = n_start;
        repeat (520) @(posedge clock_in);
        dw(REG_RATE, 8'h00);
        chk((n_start - k) inside {5, 6}, 1'b1);
        $display("test power_modes done");
        dw(REG_OSR, 8'h5C);
        dchk(REG_EFF_OSR, 8'h9C);
        dw(REG_OSR, 8'h64);
        dchk(REG_EFF_OSR, 8'h00);
        dw(REG_RATE, 8'h10);
        dchk(REG_EFF_OSR, 8'hA4);
        $display("test oversampling done");
        dw(REG_CMD, CMD_NVM_1ST);
        dchk(REG_CMD, 8'h00);
        dw(REG_CMD, CMD_NVM_WR);
        chk(nvm_prog, 1'b1);
        dw(REG_CMD, CMD_NVM_1ST);
        dw(REG_CMD, CMD_EXT_1);
        dw(REG_CMD, CMD_NVM_RD);
        chk(nvm_read, 1'b0);
        dw(REG_CMD, CMD_NVM_1ST);
        dw(REG_CMD, CMD_NVM_RD);
        chk(nvm_read, 1'b1);
        dw(REG_CMD, CMD_EXT_1);
        dw(REG_CMD, CMD_EXT_2);
        dw(REG_CMD, CMD_NVM_1ST);
        dw(REG_CMD, CMD_EXT_3);
        chk(extended_page_select, 1'b0);
        dw(REG_CMD, CMD_EXT_1);
        dw(REG_CMD, CMD_EXT_2);
        dw(REG_CMD, CMD_EXT_3);
        chk(extended_page_select, 1'b1);
        dw(REG_PAGE, 8'h00);
        chk(extended_page_select, 1'b0);
        $display("test commands done");
        wr(HOST_INT_ST, 32'h3);
        wr(HOST_INT_MK, 32'h2);
        dw(REG_CMD, 8'h12);
        apb(1'b0, HOST_STAT, 32'h0, s);
        chk(s[H_ERR_BIT], 1'b1);
        chk(irq, 1'b1);
        wr(HOST_INT_ST, 32'h2);
        repeat (2) @(negedge clock_in);
        chk(irq, 1'b0);
        wr(HOST_INT_ST, 32'h3);
        dw(REG_CMD, CMD_SOFT_RST);
        apb(1'b0, HOST_INT_ST, 32'h0, s);
        chk(s[1:0], 2'b01);
        dchk(REG_RATE, RATE_RST);
        dchk(REG_OSR, OSR_RST);
        chk({nvm_prog, nvm_read}, 2'b00);
        chk(n_srst, 32'd1);
        $display("test refusal_and_soft_reset done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
